/* design/pll_bank_divider_control.sv */
// digital control of a twelve-output pll clock fan-out driver
// What this block does
// - reference-rate feedback: select code picks zero to three banks at half rate.
// - second configuration: single-rate banks at reference, others at twice it.
// - single-rate feedback: codes give one, two, three single-rate banks, rest double.
// - clear falling edge forces the divider flip-flop low, resetting half-rate phase.
// - same reference and clear give identical half-rate phase across devices.
// - enable low drives all twelve outputs; high floats every output.
// - disabling outputs breaks the loop; re-enable needs a new settling interval.
// - test low uses the loop; test high bypasses it to the outputs.
// - banks one to three carry half or quarter oscillator rate per select.
// - with test low, bank four always carries half the oscillator rate.
// - with test low, every output has 50% duty, whatever the reference duty.
// - half-rate phase is unknown after power-up until a clear edge.
// - loop adjusts outputs until feedback has zero phase offset to reference.
// - selects switch up to nine outputs, always whole banks of three.
// - after power-up and a valid reference, outputs count unlocked until settled.
// - oscillator divided by a two-bit counter; half and quarter taps feed banks.
// - lock assumed only 50 us after power-up, select, clear or enable events.
`timescale 1ns/1ps
module pll_bank_divider_control #(
  parameter int unsigned STAB_CYCLES_P = pll_bank_pkg::STAB_CYCLES,
  parameter int unsigned STAB_W = 13,
  parameter int unsigned PERIOD_W = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic reference_clock_in,
  input wire logic loop_feedback_in,
  input wire logic half_rate_phase_clear_n_in,
  input wire logic output_enable_n_in,
  input wire logic bank_select_hi_in,
  input wire logic bank_select_lo_in,
  input wire logic loop_bypass_test_in,
  input wire logic feedback_quarter_tap_in,
  output pll_bank_pkg::bank_outputs_t bank_outputs_out,
  output pll_bank_pkg::bank_outputs_t bank_outputs_oe_out,
  output pll_bank_pkg::loop_status_t loop_status_out
);
  import pll_bank_pkg::*;

  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES_P - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; prev only ever reads the second stage
  pins_t pins_raw;
  pins_t sync_a;
  pins_t sync;
  pins_t prev;

  assign pins_raw = {reference_clock_in, loop_feedback_in, half_rate_phase_clear_n_in,
                     output_enable_n_in, bank_select_hi_in, bank_select_lo_in,
                     loop_bypass_test_in, feedback_quarter_tap_in};

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      // idle levels, so no false clear or enable edge follows reset
      sync_a <= PINS_IDLE;
      sync <= PINS_IDLE;
      prev <= PINS_IDLE;
    end else if (clk_en_in) begin
      sync_a <= pins_raw;
      sync <= sync_a;
      prev <= sync;
    end
  end

  logic ref_rise;
  logic clr_fall;
  logic oe_fall;
  logic disturb;
  logic slip;
  logic [2:0] steps;

  assign ref_rise = sync.ref_clk & ~prev.ref_clk;
  assign clr_fall = ~sync.clear_n & prev.clear_n;
  assign oe_fall = ~sync.out_en_n & prev.out_en_n;
  // a disabled output set means no feedback at all, so settling restarts
  assign disturb = clr_fall | oe_fall | sync.out_en_n | (sync.sel != prev.sel)
                 | (sync.quarter_fb != prev.quarter_fb);
  // fed-back tap already high at the reference edge: one step out of phase
  assign slip = sync.feedback & ~sync.out_en_n;
  assign steps = sync.quarter_fb ? STEPS_CONFIG_B : STEPS_CONFIG_A;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator model: steps spread evenly over each measured reference period
  logic [PERIOD_W-1:0] per_cnt;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W:0] acc;
  logic [1:0] div_q;
  logic phase_known;
  logic [PERIOD_W-1:0] next_per_cnt;
  logic [PERIOD_W-1:0] next_period;
  logic [PERIOD_W:0] next_acc;
  logic [1:0] next_div_q;
  logic next_phase_known;
  logic [PERIOD_W:0] acc_sum;

  assign acc_sum = acc + {{(PERIOD_W-2){1'b0}}, steps};

  always_comb begin
    next_per_cnt = per_cnt;
    next_period = period;
    next_acc = acc;
    next_div_q = div_q;
    next_phase_known = phase_known;
    if (per_cnt != '1) begin
      next_per_cnt = per_cnt + 1'b1;
    end
    if (clr_fall) begin
      // clear beats a coincident reference edge
      next_div_q = DIV_RESET;
      next_acc = '0;
      next_phase_known = 1'b1;
    end else if (ref_rise) begin
      // a saturated count wraps to zero, which stops the steps
      next_period = per_cnt + 1'b1;
      next_per_cnt = '0;
      next_acc = '0;
      if (!slip) begin
        next_div_q = div_q + 1'b1;
      end
    end else if (period != '0 && acc_sum >= {1'b0, period}) begin
      next_acc = acc_sum - {1'b0, period};
      next_div_q = div_q + 1'b1;
    end else begin
      next_acc = acc_sum;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      per_cnt <= '0;
      period <= '0;
      acc <= '0;
      div_q <= DIV_RESET;
      phase_known <= 1'b0;
    end else if (clk_en_in) begin
      per_cnt <= next_per_cnt;
      period <= next_period;
      acc <= next_acc;
      div_q <= next_div_q;
      phase_known <= next_phase_known;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock tracking
  lock_state_t state;
  lock_state_t next_state;
  logic [STAB_W-1:0] stab_cnt;
  logic [STAB_W-1:0] next_stab_cnt;

  always_comb begin
    next_state = state;
    next_stab_cnt = stab_cnt;
    case (state)
      ST_NO_REF: begin
        if (ref_rise) begin
          next_state = ST_SETTLING;
          next_stab_cnt = '0;
        end
      end
      ST_SETTLING: begin
        if (disturb) begin
          next_stab_cnt = '0;
        end else if (stab_cnt == STAB_LAST) begin
          next_state = ST_LOCKED;
        end else begin
          next_stab_cnt = stab_cnt + 1'b1;
        end
      end
      ST_LOCKED: begin
        if (disturb) begin
          next_state = ST_SETTLING;
          next_stab_cnt = '0;
        end
      end
      default: begin
        next_state = ST_NO_REF;
      end
    endcase
    // reference gone for a whole period count
    if (per_cnt == '1) begin
      next_state = ST_NO_REF;
      next_stab_cnt = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state <= ST_NO_REF;
      stab_cnt <= '0;
    end else if (clk_en_in) begin
      state <= next_state;
      stab_cnt <= next_stab_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank taps and output drive
  logic tap_half;
  logic tap_quarter;
  logic [RATE_BANKS-1:0] bank_tap;
  bank_outputs_t outs;
  bank_outputs_t next_outs;
  bank_outputs_t oe;
  bank_outputs_t next_oe;
  logic cfg_bad;
  logic next_cfg_bad;

  // counter bits are square waves, so duty never follows the reference
  assign tap_half = div_q[0];
  assign tap_quarter = div_q[1];

  genvar b;
  generate
    for (b = 0; b < RATE_BANKS; b++) begin : g_bank
      // whole banks only; lower banks slow down first
      assign bank_tap[b] = (2'(b) < sync.sel) ? tap_quarter : tap_half;
    end
  endgenerate

  always_comb begin
    if (sync.test) begin
      next_outs = bank_outputs_t'({(4 * OUTS_PER_BANK){sync.ref_clk}});
    end else begin
      next_outs = {{OUTS_PER_BANK{tap_half}}, {OUTS_PER_BANK{bank_tap[2]}},
                   {OUTS_PER_BANK{bank_tap[1]}}, {OUTS_PER_BANK{bank_tap[0]}}};
    end
    next_oe = bank_outputs_t'({(4 * OUTS_PER_BANK){~sync.out_en_n}});
    next_cfg_bad = sync.quarter_fb & (sync.sel == SEL_NONE);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      outs <= '0;
      oe <= '0;
      cfg_bad <= 1'b0;
    end else if (clk_en_in) begin
      outs <= next_outs;
      oe <= next_oe;
      cfg_bad <= next_cfg_bad;
    end
  end

  assign bank_outputs_out = outs;
  assign bank_outputs_oe_out = oe;
  assign loop_status_out = {state == ST_LOCKED, phase_known, cfg_bad};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_clear_edge;
    clk_en_in && clr_fall;
  endsequence

  sequence s_lock_upset;
    clk_en_in && state == ST_LOCKED && disturb && per_cnt != '1;
  endsequence

  property p_clear_resets;
    s_clear_edge |=> div_q == DIV_RESET && acc == '0 && phase_known;
  endproperty
  a_clear_resets: assert property (p_clear_resets) else $error("clear did not reset divider");

  property p_relock;
    s_lock_upset |=> state == ST_SETTLING && stab_cnt == '0;
  endproperty
  a_relock: assert property (p_relock) else $error("lock kept after disturbance");

  property p_lock_time;
    $rose(state == ST_LOCKED) |-> $past(stab_cnt) == STAB_LAST && $past(!disturb);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock before settling time");

  property p_oe_drive;
    clk_en_in ##1 clk_en_in |-> oe == bank_outputs_t'({12{~$past(sync.out_en_n)}});
  endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("output enable wrong");

  property p_test_bypass;
    clk_en_in && sync.test |=> outs == bank_outputs_t'({12{$past(sync.ref_clk)}});
  endproperty
  a_test_bypass: assert property (p_test_bypass) else $error("test bypass wrong");

  property p_bank_four;
    clk_en_in && !sync.test |=> outs.bank_four_outputs == {3{$past(div_q[0])}};
  endproperty
  a_bank_four: assert property (p_bank_four) else $error("bank four not half rate");

  property p_select_map;
    clk_en_in && !sync.test && sync.sel == 2'h2
      |=> outs.bank_two_outputs == {3{$past(div_q[1])}}
          && outs.bank_three_outputs == {3{$past(div_q[0])}};
  endproperty
  a_select_map: assert property (p_select_map) else $error("bank select map wrong");

  property p_square_taps;
    $rose(div_q[1]) |-> $fell(div_q[0]);
  endproperty
  a_square_taps: assert property (p_square_taps) else $error("quarter tap out of order");

  property p_invalid_code;
    clk_en_in && sync.quarter_fb && sync.sel == SEL_NONE |=> loop_status_out.config_invalid;
  endproperty
  a_invalid_code: assert property (p_invalid_code) else $error("invalid code not flagged");

  property p_phase_unknown;
    !phase_known && clk_en_in && !clr_fall |=> !phase_known;
  endproperty
  a_phase_unknown: assert property (p_phase_unknown) else $error("phase known without clear");
endmodule : pll_bank_divider_control

/* design/pll_bank_pkg.sv */
// constants and carrier types for the pll bank divider control
package pll_bank_pkg;
  localparam int unsigned CORE_CLK_MHZ = 100;
  localparam int unsigned STAB_TIME_US = 50;
  localparam int unsigned STAB_CYCLES = STAB_TIME_US * CORE_CLK_MHZ;
  localparam int unsigned OUTS_PER_BANK = 3;
  localparam int unsigned RATE_BANKS = 3;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [2:0] STEPS_CONFIG_A = 3'h2;
  localparam logic [2:0] STEPS_CONFIG_B = 3'h4;

  typedef enum logic [1:0] {
    ST_NO_REF = 2'b00,
    ST_SETTLING = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_t;

  typedef struct packed {
    logic ref_clk;
    logic feedback;
    logic clear_n;
    logic out_en_n;
    logic [1:0] sel;
    logic test;
    logic quarter_fb;
  } pins_t;

  // idle pin levels; clear and enable are active low, so they rest high
  localparam pins_t PINS_IDLE = pins_t'(8'h30);

  typedef struct packed {
    logic [OUTS_PER_BANK-1:0] bank_four_outputs;
    logic [OUTS_PER_BANK-1:0] bank_three_outputs;
    logic [OUTS_PER_BANK-1:0] bank_two_outputs;
    logic [OUTS_PER_BANK-1:0] bank_one_outputs;
  } bank_outputs_t;

  typedef struct packed {
    logic locked;
    logic phase_known;
    logic config_invalid;
  } loop_status_t;
endpackage : pll_bank_pkg

/* sim/ref_source_model.sv */
// board side: reference clock source and the wired-back feedback output
`timescale 1ns/1ps
module ref_source_model #(
  parameter real HALF_NS = 62.5
) (
  input wire logic core_clk_in,
  input wire logic run_in,
  input wire logic [3:0] fb_index_in,
  input wire logic [11:0] outputs_in,
  input wire logic [11:0] oe_in,
  output logic ref_clk_out,
  output logic feedback_out
);
  logic last_fb = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // fixed period and phase while running, low when stopped
  initial begin
    ref_clk_out = 1'b0;
    #3.3;
    forever begin
      #(HALF_NS);
      ref_clk_out = run_in ? ~ref_clk_out : 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one output wired back; a floating wire shows the inverse, not a stale level
  always_ff @(posedge core_clk_in) begin
    last_fb <= feedback_out;
  end
  assign feedback_out = oe_in[fb_index_in] ? outputs_in[fb_index_in] : ~last_fb;
endmodule : ref_source_model

/* sim/tb_top.sv */
// self-checking bench for the pll bank divider control
`timescale 1ns/1ps
module tb_top;
  import pll_bank_pkg::*;
  localparam int unsigned STAB = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clear_n = 1'b1;
  logic oe_n = 1'b1;
  logic [1:0] sel = 2'h0;
  logic test = 1'b0;
  logic strap = 1'b0;
  logic run = 1'b1;
  logic clk_en = 1'b1;
  logic ref_clk;
  logic fb;
  bank_outputs_t outs;
  bank_outputs_t oe;
  loop_status_t st;
  logic [2:0] stv;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] rng = 32'h00009AD4;

  assign stv = st;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  pll_bank_divider_control #(.STAB_CYCLES_P(STAB)) i_pll_bank_divider_control (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
    .reference_clock_in(ref_clk), .loop_feedback_in(fb),
    .half_rate_phase_clear_n_in(clear_n), .output_enable_n_in(oe_n),
    .bank_select_hi_in(sel[1]), .bank_select_lo_in(sel[0]),
    .loop_bypass_test_in(test), .feedback_quarter_tap_in(strap),
    .bank_outputs_out(outs), .bank_outputs_oe_out(oe), .loop_status_out(st));
  ref_source_model i_ref_source_model (
    .core_clk_in(core_clk), .run_in(run), .fb_index_in(strap ? 4'h0 : 4'h9),
    .outputs_in(outs), .oe_in(oe), .ref_clk_out(ref_clk), .feedback_out(fb));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  // window of 200 cycles holds 16 reference periods
  function automatic int exp_rises(int b, logic [1:0] s, logic cfg_b, logic tst);
    int half;
    half = cfg_b ? 32 : 16;
    if (tst) return 16;
    if (b < 3 && b < s) return half / 2;
    return half;
  endfunction : exp_rises

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic check_bits(logic [11:0] got, logic [11:0] exp, string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_bits

  // slack of a few edges for loop slips while it settles
  task automatic check_count(int got, int exp, int tol, string what);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : check_count

  task automatic settle(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic wait_status(int idx, logic v, int bound);
    int i;
    i = 0;
    comparisons++;
    while (stv[idx] !== v && i < bound) begin
      settle(1);
      i++;
    end
    if (stv[idx] !== v) begin
      miscompares++;
      $display("unexpected at %0t: status bit %0d wait ran out", $time, idx);
      print_verdict();
    end
  endtask : wait_status

  task automatic measure(logic [1:0] s, logic cfg_b, logic tst);
    int rises [12];
    int highs;
    logic [11:0] prev;
    highs = 0;
    foreach (rises[k]) rises[k] = 0;
    prev = outs;
    repeat (200) begin
      settle(1);
      for (int k = 0; k < 12; k++) if (outs[k] && !prev[k]) rises[k]++;
      highs += outs[9];
      prev = outs;
    end
    for (int k = 0; k < 12; k++) begin
      check_count(rises[k], exp_rises(k / 3, s, cfg_b, tst), 3, "rises");
    end
    check_count(highs, 100, 12, "duty");
  endtask : measure
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] s;
    logic [11:0] snap;
    logic [2:0] snap_st;
    s = 2'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    settle(0);
    check_bits(outs | oe, 12'h000, "reset outs");
    check_bits({9'h0, st}, 12'h000, "reset status");
    settle(3);
    check_bits(oe, 12'h000, "oe off");
    @(posedge core_clk);
    oe_n <= 1'b0;
    settle(4);
    check_bits(oe, 12'hFFF, "oe on");
    wait_status(2, 1'b1, 300);
    settle(xorshift() % 16);
    @(posedge core_clk);
    clear_n <= 1'b0;
    wait_status(1, 1'b1, 8);
    settle(1);
    check_bits(outs, 12'h000, "clear taps");
    settle(xorshift() % 8);
    @(posedge core_clk);
    clear_n <= 1'b1;
    // every code in both configurations; each change must restart settling
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 4; i++) begin
        settle(xorshift() % 8);
        s = s + 2'h1;
        @(posedge core_clk);
        strap <= c[0];
        sel <= s;
        settle(6);
        check_bits({10'h0, st.locked, st.config_invalid}, {11'h0, c == 1 && s == 2'h0}, "sel");
        settle(12);
        check_bits({11'h0, st.locked}, 12'h000, "lock early");
        wait_status(2, 1'b1, 100);
        if (!(c == 1 && s == 2'h0)) measure(s, c[0], 1'b0);
      end
    end
    @(posedge core_clk);
    oe_n <= 1'b1;
    settle(4);
    check_bits(oe, 12'h000, "disabled");
    check_bits({11'h0, st.locked}, 12'h000, "unlocked when disabled");
    @(posedge core_clk);
    oe_n <= 1'b0;
    settle(15);
    check_bits({11'h0, st.locked}, 12'h000, "relock early");
    wait_status(2, 1'b1, 100);
    // clock enable low freezes every flop, outputs and status alike
    @(posedge core_clk);
    clk_en <= 1'b0;
    settle(1);
    snap = outs;
    snap_st = stv;
    settle(4 + xorshift() % 16);
    check_bits(outs, snap, "frozen outs");
    check_bits({9'h0, stv}, {9'h0, snap_st}, "frozen status");
    @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    test <= 1'b1;
    settle(6);
    measure(sel, strap, 1'b1);
    @(posedge core_clk);
    test <= 1'b0;
    run <= 1'b0;
    wait_status(2, 1'b0, 300);
    print_verdict();
  end
endmodule : tb_top
